/* File: shared/rtc_pkg.sv */
`default_nettype none

package rtc_pkg;

   // -------------------------------------------------------------
   // Register map, byte addresses on APB
   // -------------------------------------------------------------
   localparam logic [7:0] OFF_WORD0 = 8'h00;
   localparam logic [7:0] OFF_CTRL = 8'h24;
   localparam logic [7:0] OFF_STAT = 8'h28;

   // -------------------------------------------------------------
   // Memory layout
   // -------------------------------------------------------------
   localparam int NWORDS = 9;
   localparam logic [3:0] CFG_ADDR = 4'h8;
   localparam logic [3:0] LAST_ADDR = 4'h8;
   localparam logic [3:0] PW_WORDS = 4'h4;
   localparam logic [3:0] CRIT_ADDR = 4'h4;
   localparam logic [7:0] TX_LAST_ALL = 8'h8f;
   localparam logic [7:0] TX_LAST_ID = 8'h7f;
   localparam logic [7:0] TX_IDLE = 8'hff;

   // -------------------------------------------------------------
   // Carrier division and timing in bit periods
   // -------------------------------------------------------------
   localparam int DIV_FAST = 32;
   localparam int DIV_SLOW = 64;
   localparam int TAS_BITS = 2;
   localparam int WINDOW_BITS = 16;
   localparam int TIMEOUT_BITS = 16;
   localparam int PHASE_BITS = 16;
   localparam logic [4:0] TAS_LAST = 5'(TAS_BITS - 1);
   localparam logic [4:0] WIN_LAST = 5'(WINDOW_BITS - 1);
   localparam logic [4:0] SYNC_TO_LAST = 5'(TIMEOUT_BITS - 1);
   localparam logic [4:0] PHASE_LAST = 5'(PHASE_BITS - 1);
   localparam logic [1:0] PAT_LAST = 2'h3;

   // Configuration word, low nibble of word 8
   typedef struct packed {
      logic partial;
      logic wlock;
      logic manch;
      logic fast;
   } rtc_cfg_s;

   typedef enum logic [5:0] {
      ST_READ = 6'h01,
      ST_PAT_DLY = 6'h02,
      ST_WAIT_SYNC = 6'h04,
      ST_RECV = 6'h08,
      ST_ERASE = 6'h10,
      ST_WRITE = 6'h20
   } rtc_st_e;

endpackage

`default_nettype wire

/* File: src/rtc_tag_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Unprotected mode: all nine words programmable
// - Unprotected mode: transmit all nine words
// - Unprotected: no password, first sync bit programs word0
// - Protected: only words four to eight rewritable
// - Protected mode: transmit eight identification words
// - Protected: first four cycles compare password words
// - Password cycle never erases or writes
// - Write-lock: ignore field, transmit 128-bit ID
// - Four field transitions stop tag modulation
// - Wait hold time before starting watchdog
// - Edge needs two samples each level
// - Four transitions within sixteen bit periods
// - No sync bit in sixteen periods: leave
// - Address clears on pattern, increments per word
// - Cycle: sync, receive, erase, write phases
// - Manchester: one rises mid-bit, zero falls
// - Biphase: toggle each bit, zero toggles mid
// - Mode latched at power-up, held until reset
// - Bit period: carrier over 32 or 64
// - Leave after ninth word, else re-arm watchdog
// - Writing word 3 latches critical read; unprotected mode only
module rtc_tag_ctrl (
   // System
   input wire logic clock,
   input wire logic rstn,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output var logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Field side
   input wire logic carrier_in,
   input wire logic field_high_level,
   output logic mod_out
);

   // -------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------
   logic [15:0] mem [rtc_pkg::NWORDS];
   logic [2:0] car_q;
   logic [1:0] fld_q;
   logic started_r;
   rtc_pkg::rtc_cfg_s cfg_r;
   logic [5:0] car_cnt_r;
   logic [3:0] smp_r;
   logic [1:0] pat_cnt_r;
   logic [4:0] pat_win_r;
   rtc_pkg::rtc_st_e st_r;
   logic [4:0] cnt_r;
   logic [3:0] addr_r;
   logic [15:0] sh_r;
   logic crit_r;
   logic [7:0] tx_idx_r;
   logic tx_bit_r;
   logic mod_r;
   logic [31:0] prdata_r;
   logic slverr_r;

   // -------------------------------------------------------------
   // Input synchronisers
   // -------------------------------------------------------------
   // Carrier and field level come from outside this clock domain
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         car_q <= 3'h0;
         fld_q <= 2'h0;
      end else if (clk_en) begin
         car_q <= {car_q[1:0], carrier_in};
         fld_q <= {fld_q[0], field_high_level};
      end
   end

   // -------------------------------------------------------------
   // Bit clock recovery
   // -------------------------------------------------------------
   wire car_rise = car_q[1] & ~car_q[2];
   wire fld = fld_q[1];
   wire [5:0] div_m1 = cfg_r.fast ? 6'(rtc_pkg::DIV_FAST - 1)
                                  : 6'(rtc_pkg::DIV_SLOW - 1);
   wire [5:0] half_m1 = cfg_r.fast ? 6'(rtc_pkg::DIV_FAST / 2 - 1)
                                   : 6'(rtc_pkg::DIV_SLOW / 2 - 1);
   wire bit_tick = started_r & car_rise & (car_cnt_r == div_m1);
   wire half_tick = started_r & car_rise & (car_cnt_r == half_m1);

   // Count carrier rising edges within one bit period
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         car_cnt_r <= 6'h00;
      end else if (clk_en && started_r && car_rise) begin
         car_cnt_r <= (car_cnt_r == div_m1) ? 6'h00 : car_cnt_r + 6'h01;
      end
   end

   // -------------------------------------------------------------
   // Field sampling and edge detection
   // -------------------------------------------------------------
   // One sample per bit; two settled samples on each side filter glitches
   wire [3:0] smp_nxt = {smp_r[2:0], fld};
   wire fld_edge = bit_tick & ((smp_nxt == 4'h3) | (smp_nxt == 4'hc));

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         smp_r <= 4'hf;
      end else if (clk_en && bit_tick) begin
         smp_r <= smp_nxt;
      end
   end

   // -------------------------------------------------------------
   // Mode decode
   // -------------------------------------------------------------
   wire unprot = ~cfg_r.wlock & ~cfg_r.partial;
   wire prot = ~cfg_r.wlock & cfg_r.partial;
   wire pw_cyc = prot & (addr_r < rtc_pkg::PW_WORDS);
   wire in_read = (st_r == rtc_pkg::ST_READ);
   // A locked tag never listens to the field
   wire pat_en = started_r & ~cfg_r.wlock & in_read;
   wire pat_hit = pat_en & fld_edge & (pat_cnt_r == rtc_pkg::PAT_LAST);

   // -------------------------------------------------------------
   // Control pattern detector
   // -------------------------------------------------------------
   // Window starts at the first edge; a slow pattern is thrown away
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pat_cnt_r <= 2'h0;
         pat_win_r <= 5'h00;
      end else if (clk_en && bit_tick) begin
         if (!pat_en || pat_hit) begin
            pat_cnt_r <= 2'h0;
            pat_win_r <= 5'h00;
         end else if (fld_edge) begin
            pat_cnt_r <= pat_cnt_r + 2'h1;
            if (pat_cnt_r == 2'h0) begin
               pat_win_r <= 5'h00;
            end
         end else if (pat_cnt_r != 2'h0) begin
            if (pat_win_r == rtc_pkg::WIN_LAST) begin
               pat_cnt_r <= 2'h0;
               pat_win_r <= 5'h00;
            end else begin
               pat_win_r <= pat_win_r + 5'h01;
            end
         end
      end
   end

   // -------------------------------------------------------------
   // Programming sequencer
   // -------------------------------------------------------------
   wire [15:0] rx_word = {sh_r[14:0], fld};
   wire phase_end = (cnt_r == rtc_pkg::PHASE_LAST);
   wire pw_bad = pw_cyc & (rx_word != mem[addr_r]);
   wire mem_clr = bit_tick & (st_r == rtc_pkg::ST_ERASE) & phase_end & ~pw_cyc;
   wire mem_we = bit_tick & (st_r == rtc_pkg::ST_WRITE) & phase_end & ~pw_cyc;

   // Advances only on bit ticks; a sync bit is one sample at low field
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st_r <= rtc_pkg::ST_READ;
         cnt_r <= 5'h00;
         addr_r <= 4'h0;
         sh_r <= 16'h0000;
      end else if (clk_en && bit_tick) begin
         case (st_r)
            rtc_pkg::ST_READ: begin
               if (pat_hit) begin
                  st_r <= rtc_pkg::ST_PAT_DLY;
                  cnt_r <= 5'h00;
                  addr_r <= 4'h0;
               end
            end
            rtc_pkg::ST_PAT_DLY: begin
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r == rtc_pkg::TAS_LAST) begin
                  st_r <= rtc_pkg::ST_WAIT_SYNC;
                  cnt_r <= 5'h00;
               end
            end
            rtc_pkg::ST_WAIT_SYNC: begin
               if (!fld) begin
                  st_r <= rtc_pkg::ST_RECV;
                  cnt_r <= 5'h00;
               end else if (cnt_r == rtc_pkg::SYNC_TO_LAST) begin
                  st_r <= rtc_pkg::ST_READ;
               end else begin
                  cnt_r <= cnt_r + 5'h01;
               end
            end
            rtc_pkg::ST_RECV: begin
               sh_r <= rx_word;
               cnt_r <= cnt_r + 5'h01;
               if (phase_end) begin
                  cnt_r <= 5'h00;
                  st_r <= pw_bad ? rtc_pkg::ST_READ : rtc_pkg::ST_ERASE;
               end
            end
            rtc_pkg::ST_ERASE: begin
               cnt_r <= cnt_r + 5'h01;
               if (phase_end) begin
                  st_r <= rtc_pkg::ST_WRITE;
                  cnt_r <= 5'h00;
               end
            end
            rtc_pkg::ST_WRITE: begin
               cnt_r <= cnt_r + 5'h01;
               if (phase_end) begin
                  cnt_r <= 5'h00;
                  addr_r <= addr_r + 4'h1;
                  st_r <= (addr_r == rtc_pkg::LAST_ADDR) ? rtc_pkg::ST_READ
                                                         : rtc_pkg::ST_WAIT_SYNC;
               end
            end
            default: begin
               st_r <= rtc_pkg::ST_READ;
            end
         endcase
      end
   end

   // Critical read latch, cleared only by power loss
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         crit_r <= 1'b0;
      end else if (clk_en && mem_we && addr_r == rtc_pkg::CRIT_ADDR - 4'h1) begin
         crit_r <= 1'b1;
      end
   end

   // -------------------------------------------------------------
   // APB decode
   // -------------------------------------------------------------
   wire apb_setup = psel & ~penable;
   wire apb_wr = psel & penable & pwrite;
   wire [3:0] apb_idx = paddr[5:2];
   wire is_word = (paddr[1:0] == 2'h0) & (paddr < rtc_pkg::OFF_CTRL);
   wire is_ctrl = (paddr == rtc_pkg::OFF_CTRL);
   wire is_stat = (paddr == rtc_pkg::OFF_STAT);
   wire mapped = is_word | is_ctrl | is_stat;
   // Memory image is only loadable before power-up is emulated
   wire apb_mem_we = apb_wr & is_word & ~started_r;
   wire start_req = apb_wr & is_ctrl & pwdata[0] & ~started_r;
   wire [31:0] stat_word = {16'h0000, cfg_r, started_r, crit_r, addr_r, st_r};
   wire [31:0] rd_mux = is_word ? {16'h0000, mem[apb_idx]} :
                        is_ctrl ? {31'h0, started_r} :
                        is_stat ? stat_word : 32'h0;

   // -------------------------------------------------------------
   // Nonvolatile word store
   // -------------------------------------------------------------
   // No reset: contents model retained memory
   always_ff @(posedge clock) begin
      if (clk_en) begin
         if (apb_mem_we) begin
            mem[apb_idx] <= pwdata[15:0];
         end else if (mem_clr) begin
            mem[addr_r] <= 16'h0000;
         end else if (mem_we) begin
            mem[addr_r] <= sh_r;
         end
      end
   end

   // Start emulates power-up; config is caught once and kept
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         started_r <= 1'b0;
         cfg_r <= '0;
      end else if (clk_en && start_req) begin
         started_r <= 1'b1;
         cfg_r <= rtc_pkg::rtc_cfg_s'(mem[rtc_pkg::CFG_ADDR][3:0]);
      end
   end

   // Read data captured in setup, answered in a one-cycle access
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         prdata_r <= 32'h0;
         slverr_r <= 1'b0;
      end else if (clk_en && apb_setup) begin
         prdata_r <= rd_mux;
         slverr_r <= ~mapped;
      end
   end

   assign prdata = prdata_r;
   assign pslverr = slverr_r;
   // Frozen clock must not let the master complete a transfer
   assign pready = clk_en;

   // -------------------------------------------------------------
   // ID transmitter
   // -------------------------------------------------------------
   wire all_nine = unprot | crit_r;
   wire [7:0] tx_last = all_nine ? rtc_pkg::TX_LAST_ALL : rtc_pkg::TX_LAST_ID;
   wire [7:0] tx_idx_nxt = (tx_idx_r == tx_last || tx_idx_r == rtc_pkg::TX_IDLE) ?
                           8'h00 : tx_idx_r + 8'h01;
   wire [15:0] tx_word = mem[tx_idx_nxt[7:4]];
   wire tx_bit_nxt = tx_word[4'hf - tx_idx_nxt[3:0]];

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tx_idx_r <= rtc_pkg::TX_IDLE;
         tx_bit_r <= 1'b0;
         mod_r <= 1'b0;
      end else if (clk_en) begin
         if (!started_r || !in_read) begin
            tx_idx_r <= rtc_pkg::TX_IDLE;
            tx_bit_r <= 1'b0;
            mod_r <= 1'b0;
         end else if (bit_tick) begin
            tx_idx_r <= tx_idx_nxt;
            tx_bit_r <= tx_bit_nxt;
            mod_r <= cfg_r.manch ? ~tx_bit_nxt : ~mod_r;
         end else if (half_tick && tx_idx_r != rtc_pkg::TX_IDLE) begin
            // No mid-bit action before the first bit has started: avoids a false edge
            if (cfg_r.manch) begin
               mod_r <= tx_bit_r;
            end else if (!tx_bit_r) begin
               mod_r <= ~mod_r;
            end
         end
      end
   end

   assign mod_out = mod_r;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (!rstn);

   sequence s_pat_enter;
      (st_r == rtc_pkg::ST_READ) ##1 (st_r == rtc_pkg::ST_PAT_DLY);
   endsequence

   a_ro_ignore: assert property (cfg_r.wlock |-> st_r == rtc_pkg::ST_READ)
      else $error("locked tag left read mode");
   a_mod_stops: assert property ((st_r != rtc_pkg::ST_READ) [*2] |-> !mod_out)
      else $error("modulation while programming");
   a_pw_no_write: assert property ((mem_we || mem_clr) |-> !pw_cyc)
      else $error("password word altered");
   a_prot_lower: assert property (mem_we && prot |-> addr_r >= rtc_pkg::PW_WORDS)
      else $error("protected word written");
   a_addr_clear: assert property (s_pat_enter |-> addr_r == 4'h0)
      else $error("address not cleared on pattern");
   a_wd_bound: assert property (st_r == rtc_pkg::ST_WAIT_SYNC |-> cnt_r <= 5'h0f)
      else $error("watchdog overran");
   a_win_bound: assert property (pat_win_r <= 5'h0f)
      else $error("pattern window overran");
   a_crit_hold: assert property (crit_r |=> crit_r)
      else $error("critical latch cleared");
   a_mode_fixed: assert property (started_r && $past(started_r) |-> $stable(cfg_r))
      else $error("mode changed after power-up");
   a_manch_mid: assert property (half_tick && clk_en && cfg_r.manch && in_read
      |=> mod_out == tx_bit_r)
      else $error("manchester mid-bit level wrong");
   a_biph_hold: assert property (half_tick && clk_en && !cfg_r.manch && in_read && tx_bit_r
      |=> $stable(mod_out))
      else $error("biphase one toggled mid-bit");

endmodule

`default_nettype wire

/* File: bench/rtc_reader_model.sv */
`timescale 1ns/1ps
`default_nettype none

// -------------------------------------------------------------
// Reader side: free-running carrier and field level
// -------------------------------------------------------------
module rtc_reader_model #(
   parameter int DIV = 32
) (
   // Field outputs
   output logic carrier_in,
   output logic field_high_level
);

   // Carrier runs free while the tag sits in the field
   initial begin
      carrier_in = 1'b0;
      field_high_level = 1'b1;
      forever #80 carrier_in = ~carrier_in;
   end

   // Level changes on the falling carrier edge, well away from the tag's counting edge
   task automatic hold(input logic lvl, input int nbits);
      @(negedge carrier_in);
      field_high_level = lvl;
      repeat (nbits * DIV - 1) @(negedge carrier_in);
   endtask

   // Three bits per level: long enough for two samples, all four edges inside the window
   task automatic send_pattern();
      hold(1'b1, 3);
      hold(1'b0, 3);
      hold(1'b1, 3);
      hold(1'b0, 3);
      hold(1'b1, 3);
   endtask

   // Sync bit, data MSB first, then steady high field for erase and write
   task automatic send_word(input logic [15:0] w);
      hold(1'b0, 1);
      for (int i = 15; i >= 0; i--) begin
         hold(w[i], 1);
      end
      hold(1'b1, 32);
   endtask

endmodule

`default_nettype wire

/* File: bench/rfid_tag_mode_and_program_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) begin \
         miscompares++; \
         $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
      end \
   end

module rfid_tag_mode_and_program_ctrl_tb;

   // -------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------
   localparam int BIT = 1024; // Clocks per bit: 32 carrier periods of 160 ns
   logic clock, rstn, clk_en, psel, penable, pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic pready, pslverr, carrier_in, field_high_level, mod_out, e;
   int miscompares, total_checks;

   // Clock generation
   initial clock = 1'b0;
   always #2.5 clock = ~clock;

   rtc_tag_ctrl dut (
      .clock(clock), .rstn(rstn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .carrier_in(carrier_in), .field_high_level(field_high_level), .mod_out(mod_out)
   );

   rtc_reader_model #(.DIV(32)) reader (
      .carrier_in(carrier_in),
      .field_high_level(field_high_level)
   );

   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   task automatic stop_test();
      if (miscompares == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // One APB transfer; waits on pready with a bound, result in q and e
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 100);
      // A transfer that never completes counts against the run
      if (n >= 100) begin
         miscompares++;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
      apb(1'b0, a, 32'h0);
      `CHK(nm, exp, q)
   endtask

   // Expected status: config, started, critical, address, state
   function automatic logic [15:0] st_word(input logic [3:0] cfg, input logic crit,
                                           input logic [3:0] ad, input logic [5:0] st);
      return {cfg, 1'b1, crit, ad, st};
   endfunction

   task automatic stat_chk(input logic [15:0] exp);
      rd_chk(rtc_pkg::OFF_STAT, {16'h0, exp}, "status");
   endtask

   // Power-up with fresh memory contents; bench reset held 20 cycles
   task automatic power_up(input logic [15:0] cfg);
      @(posedge clock);
      rstn <= 1'b0;
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      apb(1'b1, rtc_pkg::OFF_WORD0, 32'h0000_5555);
      for (int i = 1; i < 8; i++) begin
         apb(1'b1, 8'(4 * i), 32'(16'h1100 + i));
      end
      apb(1'b1, 8'({rtc_pkg::CFG_ADDR, 2'b00}), {16'h0, cfg});
   endtask

   task automatic wait_edge(output int n);
      logic prev;
      n = 0;
      prev = mod_out;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (mod_out === prev && n < 4 * BIT);
   endtask

   // Allows a few clocks of jitter from the synchronised carrier
   task automatic gap_chk(input int exp);
      int n;
      wait_edge(n);
      `CHK("mod_out gap", exp, ((n >= exp - 8) && (n <= exp + 8)) ? exp : n)
   endtask

   // Watchdog: the whole sequence needs roughly 110k cycles
   initial begin
      #700000;
      miscompares++;
      stop_test();
   end

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      int n;
      rstn = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      miscompares = 0;
      total_checks = 0;
      // Manchester, fast, unprotected
      power_up(16'h0003);
      apb(1'b1, 8'h04, 32'hffff_1234);
      rd_chk(8'h04, 32'h0000_1234, "word1 upper bits");
      apb(1'b0, 8'h30, 32'h0);
      `CHK("unmapped error", 1'b1, e)
      `CHK("unmapped data", 32'h0, q)
      apb(1'b1, rtc_pkg::OFF_CTRL, 32'h1);
      stat_chk(st_word(4'h3, 1'b0, 4'h0, rtc_pkg::ST_READ));
      apb(1'b1, 8'h20, 32'h0000_000c);
      apb(1'b1, 8'h08, 32'h0000_beef);
      stat_chk(st_word(4'h3, 1'b0, 4'h0, rtc_pkg::ST_READ));
      rd_chk(8'h08, 32'h0000_1102, "word2 after start");
      // Word 0 is 0101..., half then full bit gaps
      wait_edge(n);
      gap_chk(BIT / 2);
      gap_chk(BIT);
      gap_chk(BIT);
      // Program word 0 without password
      reader.send_pattern();
      reader.hold(1'b1, 3);
      `CHK("mod_out after pattern", 1'b0, mod_out)
      stat_chk(st_word(4'h3, 1'b0, 4'h0, rtc_pkg::ST_WAIT_SYNC));
      reader.send_word(16'hc3a5);
      `CHK("mod_out in program", 1'b0, mod_out)
      stat_chk(st_word(4'h3, 1'b0, 4'h1, rtc_pkg::ST_WAIT_SYNC));
      rd_chk(8'h00, 32'h0000_c3a5, "word0 programmed");
      repeat (17 * BIT) @(posedge clock);
      stat_chk(st_word(4'h3, 1'b0, 4'h1, rtc_pkg::ST_READ));
      // Second power-up: Biphase, fast, write-locked
      power_up(16'h0005);
      apb(1'b1, rtc_pkg::OFF_CTRL, 32'h1);
      stat_chk(st_word(4'h5, 1'b0, 4'h0, rtc_pkg::ST_READ));
      wait_edge(n);
      fork
         reader.send_pattern();
         begin
            for (int i = 0; i < 7; i++) begin
               gap_chk(BIT / 2);
               gap_chk(BIT / 2);
               gap_chk(BIT);
            end
         end
      join
      stat_chk(st_word(4'h5, 1'b0, 4'h0, rtc_pkg::ST_READ));
      stop_test();
   end

endmodule

`default_nettype wire
